// ==== hdl/ddcc_dither.sv ====
// Triangle generator that steers the oscillator modulator.
// Assumes core_clk is twice the master oscillator rate.
`timescale 1ns/100ps
`include "ddcc_map.svh"
module ddcc_dither (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic active,
    input wire ddcc_pkg::ddcc_sel_t rateSel,
    output logic [7:0] level
);
    import ddcc_pkg::*;

    logic [`DDCC_ACC_W-1:0] accReg;
    logic [`DDCC_ACC_W-1:0] accNext;
    logic [`DDCC_ACC_W-1:0] step;
    logic [1:0] shift;

    always_comb
    begin
        shift = `DDCC_RATE_SHIFT - rateSel;
        step = {{(`DDCC_ACC_W-1){1'b0}}, 1'b1} << shift;
        accNext = active ? accReg + step : '0;
        if (!active)
        begin
            level = `DDCC_DITHER_MID;
        end
        else if (accReg[`DDCC_ACC_W-1])
        begin
            level = ~accReg[`DDCC_ACC_W-2 -: 8];
        end
        else
        begin
            level = accReg[`DDCC_ACC_W-2 -: 8];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            accReg <= '0;
        end
        else if (clkEn)
        begin
            accReg <= accNext;
        end
    end
endmodule

// ==== hdl/ddcc_map.svh ====
// Register offsets, field positions, reset values and timing figures
// of the dithered clock divider control. Definitions only.
`ifndef DDCC_MAP_SVH
`define DDCC_MAP_SVH

// Register locations on the configuration port
`define DDCC_DIV_OFS 6'h02
`define DDCC_ADDR_OFS 6'h0D
`define DDCC_COMMIT_OFS 6'h3F

// Divider register fields
`define DDCC_RATE_HI 7
`define DDCC_RATE_LO 6
`define DDCC_IDLE_LOW_BIT 5
`define DDCC_EXP_HI 3
`define DDCC_EXP_LO 0

// Address register fields
`define DDCC_DEPTH_HI 7
`define DDCC_DEPTH_LO 6
`define DDCC_SWEN_BIT 5
`define DDCC_INHIBIT_BIT 3
`define DDCC_BUSID_HI 2
`define DDCC_BUSID_LO 0

// Bit 4 of both registers is never stored
`define DDCC_WR_MASK 8'hEF
`define DDCC_DIV_RESET 8'h00
`define DDCC_ADDR_RESET 8'h00
`define DDCC_RD_NONE 8'h00

// Divider exponent saturation
`define DDCC_EXP_MAX 4'h8

// Core clock runs at twice the master oscillator rate
`define DDCC_MASTER_RATIO 2
`define DDCC_CLK_MHZ 250

// Timing figures in their own units
`define DDCC_HOLDOFF_MASTER 512
`define DDCC_SLEEP_FILT_US 10
`define DDCC_NV_WRITE_MS 20

// Triangle accumulator spans 8192 master cycles at the slowest rate
`define DDCC_ACC_W 14
`define DDCC_RATE_SHIFT 2'h3
`define DDCC_DITHER_MID 8'h80

`endif

// ==== hdl/ddcc_pkg.sv ====
// Types shared by the dithered clock divider control.
// Constants live in ddcc_map.svh.
package ddcc_pkg;
    typedef logic [1:0] ddcc_sel_t;
    typedef enum logic [1:0] {GATE_HOLD, GATE_OFF, GATE_ON} ddcc_gate_t;
    typedef enum logic {NV_IDLE, NV_BUSY} ddcc_nv_t;
endpackage

// ==== hdl/ddcc_prescaler.sv ====
// Power-of-two prescaler producing the 50% output phase.
// Assumes core_clk is twice the master oscillator rate.
`timescale 1ns/100ps
`include "ddcc_map.svh"
module ddcc_prescaler #(
    parameter int CNT_W = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic run,
    input wire logic [3:0] expCode,
    output logic phase,
    output logic wrap,
    output logic [3:0] activeExp,
    output logic [CNT_W:0] halfLen
);
    import ddcc_pkg::*;

    logic [CNT_W-1:0] cntReg;
    logic [CNT_W-1:0] cntNext;
    logic phaseReg;
    logic phaseNext;
    logic [3:0] expReg;
    logic [3:0] expNext;
    logic [3:0] expDecoded;
    logic [CNT_W:0] limit;

    assign halfLen = {{CNT_W{1'b0}}, 1'b1} << expReg;
    assign phase = phaseReg;
    assign activeExp = expReg;

    always_comb
    begin
        expDecoded = (expCode > `DDCC_EXP_MAX) ? `DDCC_EXP_MAX : expCode;
        limit = halfLen - {{CNT_W{1'b0}}, 1'b1};
        wrap = run && (cntReg == limit[CNT_W-1:0]);
        cntNext = wrap ? '0 : cntReg + {{(CNT_W-1){1'b0}}, 1'b1};
        phaseNext = wrap ? ~phaseReg : phaseReg;
        expNext = expReg;
        if (!run)
        begin
            cntNext = '0;
            phaseNext = 1'b0;
        end
        // new exponent only at period end or while stopped
        if (!run || (wrap && phaseReg))
        begin
            expNext = expDecoded;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cntReg <= '0;
            phaseReg <= 1'b0;
            expReg <= `DDCC_EXP_MAX;
        end
        else if (clkEn)
        begin
            cntReg <= cntNext;
            phaseReg <= phaseNext;
            expReg <= expNext;
        end
    end
endmodule

// ==== hdl/ddcc_top.sv ====
// Control logic of the dithered clock generator: registers, output gating,
// hold-off, sleep filter, dither steering and nonvolatile save sequencing.
// Assumes a bus front end that decodes writes, stop conditions and reads.
// Function
// - Output divides master clock by two to the exponent, saturating at 256.
// - Rate field picks no dither or master clock over 2048, 4096, 8192.
// - Dither runs only with nonzero rate and the dither pin high.
// - Depth field picks plus/minus 1, 2, 4 or 8 percent.
// - Idle output is high impedance, or driven low when the idle bit is set.
// - Output runs only when awake and pin or software bit requests it.
// - After reset the output stays off for 512 master cycles.
// - Enable and disable act only on output phase boundaries, no runts.
// - Duty cycle stays at half while dithering.
// - Each divider write saves to nonvolatile memory unless the inhibit bit is set.
// - A write to the address register is always saved.
// - The commit command saves all registers.
// - Address register low bits give the bus identity low bits.
// - A save starts only after the bus stop ending the write.
// - Sleep stops the master oscillator and, unless the idle bit is set, the output buffer.
// - Leaving sleep keeps the output off for 512 master cycles.
// - Hardware disable keeps the master oscillator running.
`timescale 1ns/100ps
`include "ddcc_map.svh"
module ddcc_top #(
    parameter int NV_WRITE_CYC = `DDCC_NV_WRITE_MS * `DDCC_CLK_MHZ * 1000,
    parameter int NV_CNT_W = 23
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic regWrStrobe,
    input wire logic [5:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic busStop,
    output logic [7:0] regRdData,
    input wire logic ditherEnablePin,
    input wire logic hwEnablePin,
    input wire logic sleepPin,
    output logic clkOut,
    output logic clkOutOe,
    output logic oscRun,
    output logic [7:0] ditherLevel,
    output ddcc_pkg::ddcc_sel_t ditherDepthSel,
    output logic [2:0] busIdLowBits,
    output logic nvWriteStart,
    output logic nvBusy,
    output logic [7:0] nvDivImage,
    output logic [7:0] nvAddrImage
);
    import ddcc_pkg::*;

    localparam int HOLD_CYC = `DDCC_HOLDOFF_MASTER * `DDCC_MASTER_RATIO;
    localparam int SLEEP_CYC = `DDCC_SLEEP_FILT_US * `DDCC_CLK_MHZ;

    // Register group
    logic [7:0] divReg, divNext, addrReg, addrNext, rdReg, rdNext;
    logic wrDiv, wrAddr, wrCommit;
    // Sleep and gating group
    logic [11:0] sleepCntReg, sleepCntNext;
    logic asleepReg, asleepNext;
    logic [10:0] holdCntReg, holdCntNext;
    ddcc_gate_t gateReg, gateNext;
    logic clkOutReg, clkOutNext, oeReg, oeNext, outRequest;
    // Prescaler, dither and bus identity
    logic phase, wrap, phaseNext, ditherActive;
    logic [3:0] activeExp;
    logic [8:0] halfLen;
    logic [7:0] levelWire, levelReg;
    logic [1:0] depthReg;
    logic [2:0] busIdReg;
    // Save group
    ddcc_nv_t nvReg, nvNext;
    logic pendReg, pendNext, armedReg, armedNext, startReg, startNext;
    logic [NV_CNT_W-1:0] nvCntReg, nvCntNext;
    logic [7:0] imgDivReg, imgDivNext, imgAddrReg, imgAddrNext;

    always_comb
    begin
        wrDiv = regWrStrobe && (regAddr == `DDCC_DIV_OFS);
        wrAddr = regWrStrobe && (regAddr == `DDCC_ADDR_OFS);
        wrCommit = regWrStrobe && (regAddr == `DDCC_COMMIT_OFS);
        divNext = divReg;
        addrNext = addrReg;
        if (wrDiv)
        begin
            divNext = regWrData & `DDCC_WR_MASK;
        end
        if (wrAddr)
        begin
            addrNext = regWrData & `DDCC_WR_MASK;
        end
        unique case (regAddr)
            `DDCC_DIV_OFS: rdNext = divReg;
            `DDCC_ADDR_OFS: rdNext = addrReg;
            default: rdNext = `DDCC_RD_NONE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            divReg <= `DDCC_DIV_RESET;
            addrReg <= `DDCC_ADDR_RESET;
            rdReg <= `DDCC_RD_NONE;
        end
        else if (clkEn)
        begin
            divReg <= divNext;
            addrReg <= addrNext;
            rdReg <= rdNext;
        end
    end

    ddcc_prescaler #(
        .CNT_W(8)
    ) u_prescaler (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .run(!asleepReg),
        .expCode(divReg[`DDCC_EXP_HI:`DDCC_EXP_LO]),
        .phase(phase),
        .wrap(wrap),
        .activeExp(activeExp),
        .halfLen(halfLen)
    );

    assign ditherActive = (divReg[`DDCC_RATE_HI:`DDCC_RATE_LO] != 2'h0) && ditherEnablePin
        && !asleepReg;

    ddcc_dither u_dither (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .active(ditherActive),
        .rateSel(divReg[`DDCC_RATE_HI:`DDCC_RATE_LO]),
        .level(levelWire)
    );

    always_comb
    begin
        // pin or software bit requests output
        outRequest = hwEnablePin || addrReg[`DDCC_SWEN_BIT];
        phaseNext = wrap ? ~phase : phase;
        // Short sleep glitches never reach the oscillator
        sleepCntNext = sleepPin ? '0 : sleepCntReg;
        asleepNext = asleepReg;
        if (sleepPin)
        begin
            asleepNext = 1'b0;
        end
        else if (sleepCntReg == 12'(SLEEP_CYC - 1))
        begin
            asleepNext = 1'b1;
        end
        else
        begin
            sleepCntNext = sleepCntReg + 12'h001;
        end
        holdCntNext = holdCntReg;
        gateNext = gateReg;
        unique case (gateReg)
            GATE_HOLD:
            begin
                holdCntNext = holdCntReg + 11'h001;
                if (holdCntReg == 11'(HOLD_CYC - 1))
                begin
                    gateNext = GATE_OFF;
                end
            end
            GATE_OFF:
            begin
                if (outRequest && wrap && !phase)
                begin
                    gateNext = GATE_ON;
                end
            end
            GATE_ON:
            begin
                // stop after a full high half
                if (!outRequest && wrap && phase)
                begin
                    gateNext = GATE_OFF;
                end
            end
        endcase
        if (asleepReg)
        begin
            gateNext = GATE_HOLD;
            holdCntNext = '0;
        end
        clkOutNext = (gateNext == GATE_ON) && phaseNext;
        oeNext = (gateNext == GATE_ON) || divReg[`DDCC_IDLE_LOW_BIT];
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            sleepCntReg <= '0;
            asleepReg <= 1'b0;
            holdCntReg <= '0;
            gateReg <= GATE_HOLD;
            clkOutReg <= 1'b0;
            oeReg <= 1'b0;
            levelReg <= `DDCC_DITHER_MID;
            depthReg <= 2'h0;
            busIdReg <= 3'h0;
        end
        else if (clkEn)
        begin
            sleepCntReg <= sleepCntNext;
            asleepReg <= asleepNext;
            holdCntReg <= holdCntNext;
            gateReg <= gateNext;
            clkOutReg <= clkOutNext;
            oeReg <= oeNext;
            levelReg <= levelWire;
            depthReg <= addrReg[`DDCC_DEPTH_HI:`DDCC_DEPTH_LO];
            busIdReg <= addrReg[`DDCC_BUSID_HI:`DDCC_BUSID_LO];
        end
    end

    always_comb
    begin
        pendNext = pendReg;
        armedNext = armedReg;
        nvNext = nvReg;
        nvCntNext = nvCntReg;
        startNext = 1'b0;
        imgDivNext = imgDivReg;
        imgAddrNext = imgAddrReg;
        unique case (nvReg)
            NV_IDLE:
            begin
                if (armedReg)
                begin
                    nvNext = NV_BUSY;
                    armedNext = 1'b0;
                    startNext = 1'b1;
                    nvCntNext = '0;
                    imgDivNext = divReg;
                    imgAddrNext = addrReg;
                end
            end
            NV_BUSY:
            begin
                nvCntNext = nvCntReg + {{(NV_CNT_W-1){1'b0}}, 1'b1};
                if (nvCntReg == NV_CNT_W'(NV_WRITE_CYC - 1))
                begin
                    nvNext = NV_IDLE;
                end
            end
        endcase
        // stop arms a pending save
        // After the start logic, so an arm in the start cycle is kept
        if (busStop && pendReg)
        begin
            armedNext = 1'b1;
            pendNext = 1'b0;
        end
        if ((wrDiv && !addrReg[`DDCC_INHIBIT_BIT]) || wrAddr || wrCommit)
        begin
            pendNext = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            nvReg <= NV_IDLE;
            pendReg <= 1'b0;
            armedReg <= 1'b0;
            startReg <= 1'b0;
            nvCntReg <= '0;
            imgDivReg <= `DDCC_DIV_RESET;
            imgAddrReg <= `DDCC_ADDR_RESET;
        end
        else if (clkEn)
        begin
            nvReg <= nvNext;
            pendReg <= pendNext;
            armedReg <= armedNext;
            startReg <= startNext;
            nvCntReg <= nvCntNext;
            imgDivReg <= imgDivNext;
            imgAddrReg <= imgAddrNext;
        end
    end

    // Oscillator keeps running through a hardware disable
    logic oscReg;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            oscReg <= 1'b1;
        end
        else if (clkEn)
        begin
            oscReg <= !asleepNext;
        end
    end

    assign regRdData = rdReg;
    assign clkOut = clkOutReg;
    assign clkOutOe = oeReg;
    assign oscRun = oscReg;
    assign ditherLevel = levelReg;
    assign ditherDepthSel = depthReg;
    assign busIdLowBits = busIdReg;
    assign nvWriteStart = startReg;
    assign nvBusy = (nvReg == NV_BUSY);
    assign nvDivImage = imgDivReg;
    assign nvAddrImage = imgAddrReg;

    // Length of the current steady run of the output, for checking
    logic [9:0] runCntReg;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            runCntReg <= 10'h001;
        end
        else if (clkEn)
        begin
            runCntReg <= (clkOutNext != clkOutReg) ? 10'h001 : runCntReg + 10'h001;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n || !clkEn);

    sequence s_quiet8;
        !clkOut [*8];
    endsequence
    sequence s_save_trigger;
        (wrDiv && !addrReg[`DDCC_INHIBIT_BIT]) || wrAddr || wrCommit;
    endsequence

    a_reserved_bit_zero: assert property (!divReg[4] && !addrReg[4])
        else $error("reserved bit stored");
    a_exp_decode: assert property (
        activeExp <= `DDCC_EXP_MAX && halfLen == (9'h001 << activeExp))
        else $error("exponent decode wrong");
    a_reset_holdoff: assert property ($rose(rst_n) |-> s_quiet8)
        else $error("output active during reset hold-off");
    a_wake_holdoff: assert property ($fell(asleepReg) |-> s_quiet8)
        else $error("output active right after sleep");
    // sleep output off
    // Oscillator flag tracks sleep at once, the gate one cycle later
    a_sleep_output_off: assert property (
        asleepReg |-> !oscRun ##1 (!clkOut && gateReg == GATE_HOLD))
        else $error("output alive while asleep");
    a_drop_turns_off: assert property (
        gateReg == GATE_ON && !outRequest |-> ##[0:513] gateReg != GATE_ON)
        else $error("output stays on without request");
    a_full_high_pulse: assert property (
        $fell(clkOut) && !$past(asleepReg) |-> $past(runCntReg) == 10'($past(halfLen)))
        else $error("truncated high pulse");
    a_exp_at_boundary: assert property (
        $changed(activeExp) && !$past(asleepReg) |-> !phase && $past(phase))
        else $error("exponent changed mid period");
    a_dither_center: assert property (!ditherActive |=> ditherLevel == `DDCC_DITHER_MID)
        else $error("dither not centred while off");
    a_depth_follow: assert property (##1 ditherDepthSel == $past(addrReg[7:6]))
        else $error("depth select lags");
    a_idle_drive: assert property (
        gateReg != GATE_ON |-> clkOutOe == $past(divReg[`DDCC_IDLE_LOW_BIT]) && !clkOut)
        else $error("idle drive wrong");
    a_save_pending: assert property (s_save_trigger |=> pendReg)
        else $error("save trigger lost");
    a_arm_on_stop: assert property ($rose(armedReg) |-> $past(busStop) && $past(pendReg))
        else $error("save armed without stop");
    a_save_duration: assert property (nvWriteStart |-> nvBusy [*8])
        else $error("save ended early");
endmodule

// ==== verif/ddcc_bus_ctrl.sv ====
// Behavioural configuration-bus controller for the clock divider control.
// Assumes the block takes one strobe per byte and a one-cycle stop pulse.
`timescale 1ns/100ps
module ddcc_bus_ctrl (
    input wire logic core_clk,
    output logic regWrStrobe,
    output logic [5:0] regAddr,
    output logic [7:0] regWrData,
    output logic busStop,
    input wire logic [7:0] regRdData
);
    initial
    begin
        regWrStrobe = 1'b0;
        regAddr = 6'h00;
        regWrData = 8'h00;
        busStop = 1'b0;
    end
    // Data line released after the byte: show the inverse, not the old value
    task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWrStrobe <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrStrobe <= 1'b0;
        regWrData <= ~d;
    endtask
    task automatic send_stop();
        busStop <= 1'b1;
        @(posedge core_clk);
        busStop <= 1'b0;
    endtask
    // Registered read port: data follows the location one cycle later
    task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        repeat (2) @(posedge core_clk);
        d = regRdData;
    endtask
endmodule

// ==== verif/ddcc_top_tb.sv ====
// Self-checking bench for the dithered clock divider control.
// Assumes the bus controller model in ddcc_bus_ctrl.sv drives the register port.
`timescale 1ns/100ps
`include "ddcc_map.svh"
module ddcc_top_tb;
    import ddcc_pkg::*;
    localparam int NVC = 20;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ditherEnablePin = 1'b0;
    logic hwEnablePin = 1'b1;
    logic sleepPin = 1'b1;
    logic regWrStrobe;
    logic [5:0] regAddr;
    logic [7:0] regWrData;
    logic busStop;
    logic [7:0] regRdData;
    logic clkOut;
    logic clkOutOe;
    logic oscRun;
    logic [7:0] ditherLevel;
    ddcc_sel_t ditherDepthSel;
    logic [2:0] busIdLowBits;
    logic nvWriteStart;
    logic nvBusy;
    logic [7:0] nvDivImage;
    logic [7:0] nvAddrImage;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    int nvCount = 0;
    logic [7:0] lastDiv = 8'h00;
    logic [7:0] lastAddr = 8'h00;

    initial
    begin
        forever #2 core_clk = ~core_clk;
    end

    ddcc_top #(.NV_WRITE_CYC(NVC), .NV_CNT_W(23)) i_ddcc_top (
        .core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1),
        .regWrStrobe(regWrStrobe), .regAddr(regAddr), .regWrData(regWrData),
        .busStop(busStop), .regRdData(regRdData), .ditherEnablePin(ditherEnablePin),
        .hwEnablePin(hwEnablePin), .sleepPin(sleepPin), .clkOut(clkOut),
        .clkOutOe(clkOutOe), .oscRun(oscRun), .ditherLevel(ditherLevel),
        .ditherDepthSel(ditherDepthSel), .busIdLowBits(busIdLowBits),
        .nvWriteStart(nvWriteStart), .nvBusy(nvBusy), .nvDivImage(nvDivImage),
        .nvAddrImage(nvAddrImage)
    );

    ddcc_bus_ctrl i_ddcc_bus_ctrl (
        .core_clk(core_clk), .regWrStrobe(regWrStrobe), .regAddr(regAddr),
        .regWrData(regWrData), .busStop(busStop), .regRdData(regRdData)
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Ceiling well above the roughly 40k cycles the tests need
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    always @(posedge core_clk)
    begin
        if (nvWriteStart === 1'b1)
        begin
            nvCount++;
            lastDiv = nvDivImage;
            lastAddr = nvAddrImage;
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        i_ddcc_bus_ctrl.write_reg(a, d);
        i_ddcc_bus_ctrl.send_stop();
    endtask

    task automatic wait_level(input logic v);
        int k;
        k = 0;
        while (clkOut !== v && k < 3000)
        begin
            @(posedge core_clk);
            k++;
        end
    endtask

    // Widths of one full high half and the following low half
    task automatic halves(output int hi, output int lo);
        hi = 0;
        lo = 0;
        wait_level(1'b0);
        wait_level(1'b1);
        while (clkOut === 1'b1 && hi < 600)
        begin
            @(posedge core_clk);
            hi++;
        end
        while (clkOut === 1'b0 && lo < 600)
        begin
            @(posedge core_clk);
            lo++;
        end
    endtask

    task automatic count_high(input int n, output int h);
        h = 0;
        repeat (n)
        begin
            @(posedge core_clk);
            if (clkOut !== 1'b0)
                h++;
        end
    endtask

    initial
    begin
        logic [7:0] rd;
        logic [7:0] s0;
        int hi;
        int lo;
        int h;
        int p;
        int n0;
        int codes[6] = '{0, 1, 3, 8, 9, 15};
        cyc(20);
        check("resetLevel", ditherLevel, 16'h0080);
        check("resetOsc", oscRun, 16'h0001);
        check("resetNv", nvBusy, 16'h0000);
        rst_n <= 1'b1;
        count_high(1000, h);
        check("holdoffHigh", h, 16'h0000);
        $display("test reset done");

        wr(`DDCC_DIV_OFS, 8'hFF);
        i_ddcc_bus_ctrl.read_reg(`DDCC_DIV_OFS, rd);
        check("divRead", rd, 16'h00EF);
        wr(`DDCC_ADDR_OFS, 8'hFF);
        i_ddcc_bus_ctrl.read_reg(`DDCC_ADDR_OFS, rd);
        check("addrRead", rd, 16'h00EF);
        i_ddcc_bus_ctrl.read_reg(6'h05, rd);
        check("unmapped", rd, 16'h0000);
        i_ddcc_bus_ctrl.read_reg(`DDCC_COMMIT_OFS, rd);
        check("commitRead", rd, 16'h0000);
        for (int d = 0; d < 4; d++)
        begin
            wr(`DDCC_ADDR_OFS, {d[1:0], 6'h05});
            cyc(2);
            check("depth", ditherDepthSel, d[15:0]);
            check("busId", busIdLowBits, 16'h0005);
        end
        $display("test registers done");

        foreach (codes[i])
        begin
            p = 1 << ((codes[i] > 8) ? 8 : codes[i]);
            wr(`DDCC_DIV_OFS, {4'h0, codes[i][3:0]});
            halves(hi, lo);
            halves(hi, lo);
            check("highHalf", hi, p[15:0]);
            check("lowHalf", lo, p[15:0]);
        end
        $display("test divider done");

        hwEnablePin <= 1'b0;
        wr(`DDCC_ADDR_OFS, 8'h00);
        cyc(600);
        check("offOe", clkOutOe, 16'h0000);
        check("offOsc", oscRun, 16'h0001);
        wr(`DDCC_DIV_OFS, 8'h22);
        // New exponent lands only at the end of a high half, up to 512 cycles
        cyc(520);
        check("idleLowOe", clkOutOe, 16'h0001);
        check("idleLow", clkOut, 16'h0000);
        wr(`DDCC_ADDR_OFS, 8'h20);
        halves(hi, lo);
        check("firstHigh", hi, 16'h0004);
        check("swEnLow", lo, 16'h0004);
        $display("test gating done");

        ditherEnablePin <= 1'b1;
        wr(`DDCC_DIV_OFS, 8'h02);
        cyc(4);
        check("rateZero", ditherLevel, 16'h0080);
        for (int r = 1; r < 4; r++)
        begin
            p = 4096 << (r - 1);
            wr(`DDCC_DIV_OFS, {r[1:0], 6'h02});
            cyc(8);
            s0 = ditherLevel;
            cyc(p / 2);
            check("ditherHalf", ditherLevel === s0, 16'h0000);
            cyc(p / 2);
            check("ditherPeriod", ditherLevel, s0);
        end
        halves(hi, lo);
        check("ditherDuty", hi, lo);
        ditherEnablePin <= 1'b0;
        cyc(4);
        check("pinOff", ditherLevel, 16'h0080);
        $display("test dither done");

        // Held past two output periods plus the 10 us deglitch time
        sleepPin <= 1'b0;
        cyc(2600);
        check("sleepOsc", oscRun, 16'h0000);
        check("sleepOut", clkOut, 16'h0000);
        sleepPin <= 1'b1;
        count_high(1000, h);
        check("wakeHoldoff", h, 16'h0000);
        halves(hi, lo);
        check("wakeHigh", hi, 16'h0004);
        $display("test sleep done");

        cyc(30);
        n0 = nvCount;
        i_ddcc_bus_ctrl.write_reg(`DDCC_ADDR_OFS, 8'h20);
        cyc(30);
        check("noStopSave", nvCount, n0);
        i_ddcc_bus_ctrl.send_stop();
        cyc(4);
        check("stopSave", nvCount, n0 + 1);
        check("addrImage", lastAddr, 16'h0020);
        cyc(25);
        wr(`DDCC_DIV_OFS, 8'h05);
        cyc(25);
        check("autoSave", nvCount, n0 + 2);
        check("divImage", lastDiv, 16'h0005);
        // Frequent writer: inhibit autosave, then commit once
        wr(`DDCC_ADDR_OFS, 8'h28);
        cyc(25);
        check("inhibitSave", nvCount, n0 + 3);
        wr(`DDCC_DIV_OFS, 8'h06);
        cyc(25);
        check("noAutoSave", nvCount, n0 + 3);
        wr(`DDCC_COMMIT_OFS, 8'h00);
        cyc(25);
        check("commitSave", nvCount, n0 + 4);
        check("commitDiv", lastDiv, 16'h0006);
        check("commitAddr", lastAddr, 16'h0028);
        $display("test nonvolatile done");
        tally_and_finish();
    end
endmodule
